// [design/sfswr_pkg.sv]
// constants and carrier types for the serial flash status write and read sequencer
package sfswr_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS = 40;
  // self-timed status write cycle length, held as a time
  localparam int TW_NS = 10000;
  localparam int TW_CYC = (TW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] TW_COUNT = 16'(TW_CYC);

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_WR_SR2 = 8'h31;
  localparam logic [7:0] OP_GEN_WR = 8'h01;
  localparam logic [7:0] OP_WR_SR3_A = 8'hc0;
  localparam logic [7:0] OP_WR_SR3_B = 8'h11;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_WIDE = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_FAST_WIDE = 8'h0c;
  localparam logic [7:0] OP_DUAL = 8'h3b;

  // ==========================================================
  // status registers
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] SR3_RESET = 8'h04;
  localparam logic [7:0] SR2_WMASK = 8'hfe;
  localparam logic [7:0] SR3_WMASK = 8'hfa;
  localparam int SR3_PWRUP_BIT = 1;
  localparam int SR3_MODE_BIT = 0;

  // ==========================================================
  // bit, clock and byte counts per phase
  localparam logic [5:0] BITS_BYTE = 6'h08;
  localparam logic [5:0] BITS_ADDR3 = 6'h18;
  localparam logic [5:0] BITS_ADDR4 = 6'h20;
  localparam logic [5:0] DUMMY_CLKS = 6'h08;
  localparam logic [5:0] DUMMY_CLKS_QUAD = 6'h02;
  localparam logic [2:0] GEN_MAX_BYTES = 3'h3;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_WBYTE, ST_SKIP
  } sfswr_state_e;

  typedef enum logic [1:0] {WR_SR2, WR_SR3, WR_GEN} sfswr_wr_e;

  typedef struct packed {
    logic sclk;
    logic csn;
    logic [3:0] dq;
  } sfswr_pin_in_s;

  typedef struct packed {
    logic [3:0] dqOut;
    logic [3:0] dqOe;
  } sfswr_pin_out_s;

endpackage

// [design/sfswr_core.sv]
// serial flash command sequencer: status register 2/3 writes and array reads
module sfswr_core import sfswr_pkg::*; #(
  parameter int ADDR_W = 25
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial pins
  input wire sfswr_pin_in_s pinsIn,
  output sfswr_pin_out_s pinsOut,
  // mode and state from the rest of the device
  input wire logic fourLineCmdMode,
  input wire logic writeEnLatch,
  input wire logic arrayBusy,
  input wire logic [7:0] extAddrByte,
  // array read port, data one clock after memRd
  output logic [ADDR_W-1:0] memAddr,
  output logic memRd,
  input wire logic [7:0] memData,
  // status
  output logic [7:0] status2,
  output logic [7:0] status3,
  output logic wipFlag,
  output logic curAddrModeFlag
);

  // ==========================================================
  // elaboration checks
  if (ADDR_W < 24 || ADDR_W > 32) begin : g_bad_width
    $error("ADDR_W must be 24 to 32");
  end

  // ==========================================================
  // helpers
  function automatic logic [5:0] clocksFor(input logic [5:0] bits, input logic quad);
    return quad ? (bits >> 2) : bits;
  endfunction

  function automatic logic [7:0] mergeBits(input logic [7:0] old, input logic [7:0] nw,
                                           input logic [7:0] mask);
    return (old & ~mask) | (nw & mask);
  endfunction

  // ==========================================================
  // reset release and pin synchronisers
  logic [1:0] rstSync_r;
  logic rstn;
  sfswr_pin_in_s sync1_r, sync2_r;
  logic sclkLast_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstn = rstSync_r[1];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= '{sclk: 1'b0, csn: 1'b1, dq: 4'h0};
      sync2_r <= '{sclk: 1'b0, csn: 1'b1, dq: 4'h0};
      sclkLast_r <= 1'b0;
    end else begin
      sync1_r <= pinsIn;
      sync2_r <= sync1_r;
      sclkLast_r <= sync2_r.sclk;
    end
  end

  logic sclkRise, sclkFall, csnHigh;
  assign sclkRise = sync2_r.sclk & ~sclkLast_r;
  assign sclkFall = ~sync2_r.sclk & sclkLast_r;
  assign csnHigh = sync2_r.csn;

  // ==========================================================
  // sequencer state
  sfswr_state_e state_r, state_nxt;
  logic [5:0] cnt_r, cnt_nxt, target_r, target_nxt, dummy_r, dummy_nxt;
  logic [31:0] inSh_r, inSh_nxt;
  logic [2:0] lanes_r, lanes_nxt;
  logic [7:0] outSh_r, outSh_nxt, fetch_r, fetch_nxt;
  logic [2:0] outCnt_r, outCnt_nxt;
  logic [ADDR_W-1:0] memAddr_r, memAddr_nxt;
  logic memRd_r, memRd_nxt, rdPend_r, rdPend_nxt;
  sfswr_wr_e wrKind_r, wrKind_nxt;
  logic [2:0] wrBytes_r, wrBytes_nxt;
  logic [7:0] sr2New_r, sr2New_nxt, sr3New_r, sr3New_nxt;
  logic [7:0] sr2_r, sr2_nxt, sr3_r, sr3_nxt;
  logic wip_r, wip_nxt, curMode_r, curMode_nxt, initDone_r, initDone_nxt;
  logic [15:0] wipCnt_r, wipCnt_nxt;
  sfswr_pin_out_s pout_r, pout_nxt;

  logic [31:0] shiftIn;
  logic [5:0] cntInc;
  logic [31:0] rawAddr;
  logic [7:0] word;
  logic [2:0] perByte;
  logic phaseDone, busy, wrOk, isRead, wide;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    target_nxt = target_r;
    dummy_nxt = dummy_r;
    inSh_nxt = inSh_r;
    lanes_nxt = lanes_r;
    outSh_nxt = outSh_r;
    outCnt_nxt = outCnt_r;
    fetch_nxt = fetch_r;
    memAddr_nxt = memAddr_r;
    memRd_nxt = 1'b0;
    rdPend_nxt = memRd_r;
    wrKind_nxt = wrKind_r;
    wrBytes_nxt = wrBytes_r;
    sr2New_nxt = sr2New_r;
    sr3New_nxt = sr3New_r;
    sr2_nxt = sr2_r;
    sr3_nxt = sr3_r;
    wip_nxt = wip_r;
    wipCnt_nxt = wipCnt_r;
    curMode_nxt = curMode_r;
    initDone_nxt = 1'b1;
    pout_nxt = pout_r;
    word = outSh_r;
    perByte = 3'h0;
    isRead = 1'b0;
    wide = 1'b0;
    rawAddr = 32'h0;
    wrOk = 1'b0;
    // four-line mode takes a nibble per clock, upper nibble first
    shiftIn = fourLineCmdMode ? {inSh_r[27:0], sync2_r.dq}
                              : {inSh_r[30:0], sync2_r.dq[0]};
    cntInc = cnt_r + 6'h01;
    phaseDone = sclkRise && (cntInc == target_r);
    busy = arrayBusy | wip_r;

    // the power-up bit is sampled once after reset release
    if (!initDone_r) begin
      curMode_nxt = sr3_r[SR3_PWRUP_BIT];
    end

    if (rdPend_r) begin
      fetch_nxt = memData;
    end

    if (wip_r) begin
      if (wipCnt_r == 16'h1) begin
        wip_nxt = 1'b0;
      end
      wipCnt_nxt = wipCnt_r - 16'h1;
    end

    if (csnHigh) begin
      // drivers drop one clock after select is first seen high
      pout_nxt.dqOe = 4'h0;
      state_nxt = ST_CMD;
      cnt_nxt = 6'h0;
      inSh_nxt = 32'h0;
      target_nxt = clocksFor(BITS_BYTE, fourLineCmdMode);
      wrOk = (wrKind_r == WR_GEN) ? (wrBytes_r != 3'h0 && wrBytes_r <= GEN_MAX_BYTES)
                                  : (wrBytes_r == 3'h1);
      if (state_r == ST_WBYTE && cnt_r == 6'h0 && wrOk) begin
        if (wrKind_r == WR_SR2 || (wrKind_r == WR_GEN && wrBytes_r >= 3'h2)) begin
          sr2_nxt = mergeBits(sr2_r, sr2New_r, SR2_WMASK);
        end
        if (wrKind_r == WR_SR3 || (wrKind_r == WR_GEN && wrBytes_r == 3'h3)) begin
          sr3_nxt = mergeBits(sr3_r, sr3New_r, SR3_WMASK);
        end
        wip_nxt = 1'b1;
        wipCnt_nxt = TW_COUNT;
      end
    end else begin
      if (sclkRise && !phaseDone) begin
        cnt_nxt = cntInc;
        inSh_nxt = shiftIn;
      end
      unique case (state_r)
        ST_CMD: begin
          if (phaseDone) begin
            cnt_nxt = 6'h0;
            inSh_nxt = 32'h0;
            state_nxt = ST_SKIP;
            lanes_nxt = fourLineCmdMode ? 3'h4 : 3'h1;
            dummy_nxt = 6'h0;
            wrBytes_nxt = 3'h0;
            unique case (shiftIn[7:0])
              OP_READ: begin
                isRead = !fourLineCmdMode;
              end
              OP_READ_WIDE: begin
                isRead = !fourLineCmdMode;
                wide = 1'b1;
              end
              OP_FAST: begin
                isRead = 1'b1;
                dummy_nxt = fourLineCmdMode ? DUMMY_CLKS_QUAD : DUMMY_CLKS;
              end
              OP_FAST_WIDE: begin
                isRead = 1'b1;
                wide = 1'b1;
                dummy_nxt = fourLineCmdMode ? DUMMY_CLKS_QUAD : DUMMY_CLKS;
              end
              OP_DUAL: begin
                isRead = !fourLineCmdMode;
                lanes_nxt = 3'h2;
                dummy_nxt = DUMMY_CLKS;
              end
              OP_WR_SR2: begin
                wrKind_nxt = WR_SR2;
                state_nxt = (busy || !writeEnLatch) ? ST_SKIP : ST_WBYTE;
              end
              OP_WR_SR3_A, OP_WR_SR3_B: begin
                wrKind_nxt = WR_SR3;
                state_nxt = (busy || !writeEnLatch) ? ST_SKIP : ST_WBYTE;
              end
              OP_GEN_WR: begin
                wrKind_nxt = WR_GEN;
                state_nxt = (busy || !writeEnLatch) ? ST_SKIP : ST_WBYTE;
              end
              default: begin
              end
            endcase
            if (isRead && !busy) begin
              state_nxt = ST_ADDR;
              target_nxt = clocksFor((wide || curMode_r) ? BITS_ADDR4 : BITS_ADDR3,
                                     fourLineCmdMode);
            end else begin
              target_nxt = clocksFor(BITS_BYTE, fourLineCmdMode);
            end
          end
        end
        ST_ADDR: begin
          if (phaseDone) begin
            cnt_nxt = 6'h0;
            // three-byte mode prefixes the extended address byte
            rawAddr = (target_r == clocksFor(BITS_ADDR4, fourLineCmdMode)) ? shiftIn
                      : {extAddrByte, shiftIn[23:0]};
            memAddr_nxt = rawAddr[ADDR_W-1:0];
            memRd_nxt = 1'b1;
            outCnt_nxt = 3'h0;
            target_nxt = dummy_r;
            state_nxt = (dummy_r == 6'h0) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // dummy clocks are counted, their input is ignored
          if (phaseDone) begin
            cnt_nxt = 6'h0;
            state_nxt = ST_DATA;
          end
        end
        ST_DATA: begin
          cnt_nxt = 6'h0;
          if (sclkFall) begin
            perByte = (lanes_r == 3'h4) ? 3'h2 : ((lanes_r == 3'h2) ? 3'h4 : 3'h0);
            word = (outCnt_r == 3'h0) ? fetch_r : outSh_r;
            unique case (lanes_r)
              3'h4: begin
                pout_nxt.dqOut = word[7:4];
                pout_nxt.dqOe = 4'hf;
                outSh_nxt = {word[3:0], 4'h0};
              end
              3'h2: begin
                pout_nxt.dqOut = {2'h0, word[7:6]};
                pout_nxt.dqOe = 4'h3;
                outSh_nxt = {word[5:0], 2'h0};
              end
              default: begin
                pout_nxt.dqOut = {2'h0, word[7], 1'b0};
                pout_nxt.dqOe = 4'h2;
                outSh_nxt = {word[6:0], 1'b0};
              end
            endcase
            outCnt_nxt = ((outCnt_r == 3'h0) ? perByte : outCnt_r) - 3'h1;
            if (outCnt_r == 3'h0) begin
              // prefetch the next byte; the counter rolls over at the top
              memAddr_nxt = memAddr_r + ADDR_W'(1);
              memRd_nxt = 1'b1;
            end
          end
        end
        ST_WBYTE: begin
          if (phaseDone) begin
            cnt_nxt = 6'h0;
            inSh_nxt = 32'h0;
            if (wrBytes_r != 3'h7) begin
              wrBytes_nxt = wrBytes_r + 3'h1;
            end
            unique case (wrKind_r)
              WR_SR2: begin
                sr2New_nxt = shiftIn[7:0];
              end
              WR_SR3: begin
                sr3New_nxt = shiftIn[7:0];
              end
              default: begin
                if (wrBytes_r == 3'h1) begin
                  sr2New_nxt = shiftIn[7:0];
                end
                if (wrBytes_r == 3'h2) begin
                  sr3New_nxt = shiftIn[7:0];
                end
              end
            endcase
          end
        end
        default: begin
          cnt_nxt = 6'h0;
        end
      endcase
    end
    // the mode flag in status three mirrors the live address mode
    sr3_nxt[SR3_MODE_BIT] = curMode_nxt;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_CMD;
      cnt_r <= 6'h0;
      target_r <= BITS_BYTE;
      dummy_r <= 6'h0;
      inSh_r <= 32'h0;
      lanes_r <= 3'h1;
      outSh_r <= 8'h0;
      outCnt_r <= 3'h0;
      fetch_r <= 8'h0;
      memAddr_r <= '0;
      memRd_r <= 1'b0;
      rdPend_r <= 1'b0;
      wrKind_r <= WR_SR2;
      wrBytes_r <= 3'h0;
      sr2New_r <= 8'h0;
      sr3New_r <= 8'h0;
      sr2_r <= SR2_RESET;
      sr3_r <= SR3_RESET;
      wip_r <= 1'b0;
      wipCnt_r <= 16'h0;
      curMode_r <= 1'b0;
      initDone_r <= 1'b0;
      pout_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      target_r <= target_nxt;
      dummy_r <= dummy_nxt;
      inSh_r <= inSh_nxt;
      lanes_r <= lanes_nxt;
      outSh_r <= outSh_nxt;
      outCnt_r <= outCnt_nxt;
      fetch_r <= fetch_nxt;
      memAddr_r <= memAddr_nxt;
      memRd_r <= memRd_nxt;
      rdPend_r <= rdPend_nxt;
      wrKind_r <= wrKind_nxt;
      wrBytes_r <= wrBytes_nxt;
      sr2New_r <= sr2New_nxt;
      sr3New_r <= sr3New_nxt;
      sr2_r <= sr2_nxt;
      sr3_r <= sr3_nxt;
      wip_r <= wip_nxt;
      wipCnt_r <= wipCnt_nxt;
      curMode_r <= curMode_nxt;
      initDone_r <= initDone_nxt;
      pout_r <= pout_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign pinsOut = pout_r;
  assign memAddr = memAddr_r;
  assign memRd = memRd_r;
  assign status2 = sr2_r;
  assign status3 = sr3_r;
  assign wipFlag = wip_r;
  assign curAddrModeFlag = curMode_r;

endmodule

// [test/sfswr_core_properties.sv]
// concurrent checks on the sequencer ports
module sfswr_core_props import sfswr_pkg::*; #(
  parameter int ADDR_W = 25
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial pins
  input wire sfswr_pin_in_s pinsIn,
  input wire sfswr_pin_out_s pinsOut,
  // device state
  input wire logic writeEnLatch,
  input wire logic arrayBusy,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic memRd,
  input wire logic [7:0] status2,
  input wire logic [7:0] status3,
  input wire logic wipFlag,
  input wire logic curAddrModeFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====
  // helpers
  logic [15:0] wipCnt_r;
  logic [15:0] wipCnt_nxt;
  logic [2:0] age_r;
  logic [2:0] age_nxt;
  logic [ADDR_W-1:0] last_r;
  logic [ADDR_W-1:0] last_nxt;
  logic seen_r;
  logic seen_nxt;
  always_comb begin
    wipCnt_nxt = wipFlag ? wipCnt_r + 16'h1 : 16'h0;
    // saturates well after the mode flag has been loaded
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
    last_nxt = memRd ? memAddr : last_r;
    seen_nxt = pinsIn.csn ? 1'b0 : (seen_r | memRd);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wipCnt_r <= 16'h0;
      age_r <= 3'h0;
      last_r <= '0;
      seen_r <= 1'b0;
    end else begin
      wipCnt_r <= wipCnt_nxt;
      age_r <= age_nxt;
      last_r <= last_nxt;
      seen_r <= seen_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // =====
  // properties
  chk_oe_on_csn: assert property (pinsIn.csn [*4] |-> pinsOut.dqOe == 4'h0)
    else $error("output still driven after deselect");
  chk_oe_lanes: assert property (pinsOut.dqOe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal output enable pattern");
  chk_busy_silent: assert property (
    (arrayBusy || wipFlag) |-> !memRd && pinsOut.dqOe == 4'h0)
    else $error("read served while busy");
  chk_wip_len: assert property ($fell(wipFlag) |-> wipCnt_r == TW_COUNT)
    else $error("write cycle length wrong");
  chk_write_starts: assert property (
    ($changed(status2) || $changed(status3)) |-> ##[0:1] $rose(wipFlag))
    else $error("status changed without write cycle");
  chk_write_enable_cmd_gate: assert property ($rose(wipFlag) |-> writeEnLatch)
    else $error("status write without enable");
  chk_mode_bit: assert property (status3[SR3_MODE_BIT] == curAddrModeFlag)
    else $error("mode flag and status bit differ");
  chk_mode_fixed: assert property (age_r == 3'h7 |-> $stable(curAddrModeFlag))
    else $error("address mode moved after startup");
  chk_addr_step: assert property (memRd && seen_r |-> memAddr == ADDR_W'(last_r + 1'b1))
    else $error("read address did not step by one");
endmodule

bind sfswr_core sfswr_core_props #(.ADDR_W(ADDR_W)) props (
  .clk, .resetn, .pinsIn, .pinsOut, .writeEnLatch, .arrayBusy,
  .memAddr, .memRd, .status2, .status3, .wipFlag, .curAddrModeFlag
);

// [test/sfswr_host.sv]
// host controller model driving the serial pins
module sfswr_host import sfswr_pkg::*; (
  // clock
  input wire logic clk,
  // pins
  output sfswr_pin_in_s pins,
  input wire sfswr_pin_out_s pout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk = 1'b0;
  logic csn = 1'b1;
  logic hOe = 1'b0;
  logic [3:0] hDq = 4'h0;
  logic [3:0] junk = 4'h5;
  logic [3:0] lvl;
  // released lines flip every cycle so a stale level never passes
  always @(posedge clk) junk <= ~junk;
  assign lvl = (pout.dqOut & pout.dqOe) | (~pout.dqOe & (hOe ? hDq : junk));
  assign pins = '{sclk: sclk, csn: csn, dq: lvl};
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one serial clock: drive after the fall, sample at the rise
  task automatic clk1(input logic [3:0] d, input logic oe, output logic [3:0] q);
    sclk <= 1'b0;
    hDq <= d;
    hOe <= oe;
    wt(5);
    sclk <= 1'b1;
    q = lvl;
    wt(5);
  endtask
  task automatic put(input logic [31:0] v, input int n, input int w);
    logic [3:0] q;
    for (int k = 0; k < n; k += w) begin
      clk1(w == 4 ? v[31:28] : {3'h0, v[31]}, 1'b1, q);
      v = v << w;
    end
  endtask
  task automatic get(input int w, output logic [7:0] b);
    logic [3:0] q;
    b = 8'h00;
    for (int k = 0; k < 8; k += w) begin
      clk1(4'h0, 1'b0, q);
      b = (w == 1) ? {b[6:0], q[1]} : (w == 2) ? {b[5:0], q[1:0]} : {b[3:0], q};
    end
  endtask
  task automatic sel();
    csn <= 1'b0;
    wt(5);
  endtask
  task automatic desel();
    sclk <= 1'b0;
    hOe <= 1'b0;
    wt(5);
    csn <= 1'b1;
    wt(6);
  endtask
endmodule

// [test/sfswr_core_bench.sv]
// self-checking bench for the status write and read sequencer
module sfswr_core_bench import sfswr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] op;
    bit a4;
    int dum;
    int w;
    bit q;
    logic [31:0] a;
    logic [24:0] base;
  } sfswr_row_s;
  typedef struct {
    logic [7:0] op;
    logic [23:0] d;
    int n;
    bit q;
    bit we;
    logic ok;
    logic [7:0] e2;
    logic [7:0] e3;
  } sfswr_wr_s;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic fourLine = 1'b0;
  logic wel = 1'b0;
  logic busy = 1'b0;
  // counts clocks with any output enabled; one writer only, scenarios take a mark
  int oeCnt = 0;
  int oeMark = 0;
  // extended address reaches the upper array half in 3-byte mode
  logic [7:0] extAddr = 8'h01;
  logic [7:0] memData = 8'h00;
  wire sfswr_pin_in_s pinsIn;
  wire sfswr_pin_out_s pinsOut;
  wire logic [24:0] memAddr;
  wire logic memRd;
  wire logic [7:0] status2;
  wire logic [7:0] status3;
  wire logic wipFlag;
  wire logic curMode;
  int failures = 0;
  int compares = 0;
  sfswr_row_s rows [7] = '{
    '{OP_READ, 0, 0, 1, 0, 32'h00fffffe, 25'h1fffffe},
    '{OP_READ_WIDE, 1, 0, 1, 0, 32'h00abcdef, 25'h0abcdef},
    '{OP_FAST, 0, 8, 1, 0, 32'h00000010, 25'h1000010},
    '{OP_FAST_WIDE, 1, 8, 1, 0, 32'h01000020, 25'h1000020},
    '{OP_DUAL, 0, 8, 2, 0, 32'h00123456, 25'h1123456},
    '{OP_FAST, 0, 2, 4, 1, 32'h0000ff00, 25'h100ff00},
    '{OP_FAST_WIDE, 1, 2, 4, 1, 32'h01ffffff, 25'h1ffffff}
  };
  sfswr_wr_s wrs [9] = '{
    '{OP_WR_SR2, 24'ha60000, 1, 0, 1, 1, 8'ha6, 8'h04},
    '{OP_WR_SR3_A, 24'hf90000, 1, 0, 1, 1, 8'ha6, 8'hfc},
    '{OP_WR_SR3_B, 24'h080000, 1, 0, 1, 1, 8'ha6, 8'h0c},
    '{OP_GEN_WR, 24'h005c70, 3, 0, 1, 1, 8'h5c, 8'h74},
    '{OP_WR_SR2, 24'h3e0000, 1, 1, 1, 1, 8'h3e, 8'h74},
    '{OP_WR_SR3_A, 24'ha80000, 1, 1, 1, 1, 8'h3e, 8'hac},
    '{OP_GEN_WR, 24'h008000, 2, 0, 1, 1, 8'h80, 8'hac},
    '{OP_WR_SR2, 24'h111100, 2, 0, 1, 0, 8'h80, 8'hac},
    '{OP_WR_SR2, 24'h110000, 1, 0, 0, 0, 8'h80, 8'hac}
  };
  initial forever #20 clk = ~clk;
  function automatic logic [7:0] memByte(input logic [24:0] a);
    return a[7:0] ^ a[15:8] ^ {a[24:23], 6'h15};
  endfunction
  // array answers one clock after the read pulse
  always @(posedge clk) if (memRd) memData <= memByte(memAddr);
  always @(posedge clk) if (pinsOut.dqOe !== 4'h0) oeCnt <= oeCnt + 1;
  sfswr_core #(.ADDR_W(25)) dut (
    .clk(clk), .resetn(resetn), .pinsIn(pinsIn), .pinsOut(pinsOut),
    .fourLineCmdMode(fourLine), .writeEnLatch(wel), .arrayBusy(busy),
    .extAddrByte(extAddr), .memAddr(memAddr), .memRd(memRd), .memData(memData),
    .status2(status2), .status3(status3), .wipFlag(wipFlag), .curAddrModeFlag(curMode)
  );
  sfswr_host host (.clk(clk), .pins(pinsIn), .pout(pinsOut));
  // =====
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic rd(input sfswr_row_s r, input int nb, input bit ok, input int part);
    int iw;
    logic [3:0] q;
    logic [7:0] b;
    iw = r.q ? 4 : 1;
    fourLine <= r.q;
    host.sel();
    host.put({r.op, 24'h0}, 8, iw);
    host.put(r.a4 ? r.a : {r.a[23:0], 8'h0}, r.a4 ? 32 : 24, iw);
    repeat (r.dum) host.clk1(4'h0, 1'b0, q);
    for (int i = 0; i < nb; i++) begin
      host.get(r.w, b);
      if (ok) chk("read byte", b, memByte(r.base + 25'(i)));
    end
    repeat (part) host.clk1(4'h0, 1'b0, q);
    host.desel();
  endtask
  task automatic wr(input sfswr_wr_s w);
    int lw;
    lw = w.q ? 4 : 1;
    fourLine <= w.q;
    wel <= w.we;
    host.sel();
    host.put({w.op, 24'h0}, 8, lw);
    host.put({w.d, 8'h0}, 8 * w.n, lw);
    host.desel();
  endtask
  task automatic idle();
    int g;
    for (g = 0; g < TW_CYC + 20 && wipFlag !== 1'b0; g++) @(posedge clk);
    if (g >= TW_CYC + 20) begin
      failures++;
      test_done();
    end
  endtask
  // =====
  // sequence
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (rows[i]) rd(rows[i], 3, 1, 0);
    foreach (wrs[i]) begin
      wr(wrs[i]);
      chk("write busy", wipFlag, wrs[i].ok);
      if (i == 0) begin
        oeMark = oeCnt;
        rd(rows[2], 1, 0, 0);
        chk("read in write", oeCnt - oeMark, 0);
      end
      idle();
      chk("status2", status2, wrs[i].e2);
      chk("status3", status3, wrs[i].e3);
    end
    busy <= 1'b1;
    oeMark = oeCnt;
    rd(rows[1], 1, 0, 0);
    busy <= 1'b0;
    chk("read in erase", oeCnt - oeMark, 0);
    rd(rows[0], 1, 1, 3);
    chk("release", pinsOut.dqOe, 4'h0);
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    chk("status2", status2, SR2_RESET);
    chk("status3", status3, SR3_RESET);
    chk("mode", curMode, 1'b0);
    chk("wip", wipFlag, 1'b0);
    rd(rows[4], 2, 1, 0);
    test_done();
  end
endmodule
